// File: bench/dsw_poller.sv
// remote controller model that polls the status words
`timescale 1ns/1ps
module dsw_poller (
	// clock
	input  wire logic        i_clk,
	// answer from the bank
	input  wire logic [15:0] i_rdata,
	input  wire logic        i_rvalid,
	// request to the bank
	output logic             o_rd,
	output logic             o_wr,
	output logic [3:0]       o_addr
);
	//////////////////////////////////////////////////////////////////////
	// idle request lines from time zero
	initial begin
		o_rd = 1'b0;
		o_wr = 1'b0;
		o_addr = 4'h0;
	end
	// one read, or two back to back; answer sampled at the falling edge after take
	task automatic poll(input logic [3:0] a, input logic [3:0] b,
		input bit two, output logic [15:0] d1, output logic [15:0] d2,
		output bit ok);
		@(negedge i_clk);
		o_rd = 1'b1;
		o_addr = a;
		@(negedge i_clk);
		d2 = 16'h0000;
		ok = 1'b1;
		if (two) begin
			o_addr = b;
			d1 = i_rdata;
			ok = (i_rvalid === 1'b1);
			@(negedge i_clk);
		end
		o_rd = 1'b0;
		// released address toggles so a stale index is never reused
		o_addr = ~o_addr;
		if (two) begin
			d2 = i_rdata;
		end else begin
			d1 = i_rdata;
		end
		ok = ok && (i_rvalid === 1'b1);
	endtask
	// write attempt; samples the answer strobe once, one cycle after the write is released
	task automatic write_try(input logic [3:0] a, output logic seen);
		@(negedge i_clk);
		o_wr = 1'b1;
		o_addr = a;
		@(negedge i_clk);
		o_wr = 1'b0;
		o_addr = ~a;
		@(negedge i_clk);
		seen = i_rvalid;
	endtask
endmodule

// File: bench/testbench.sv
// self-checking bench for the status word bank
`timescale 1ns/1ps
module testbench;
	typedef struct {
		logic [8:0]  fl;
		logic [3:0]  a;
		logic [15:0] e;
	} dsw_row_s;
	logic        clk, rst, jog, fc, fa, cc, lk, rd, wr, rvalid, seen;
	logic [1:0]  run, dir;
	logic [7:0]  fault, warn;
	logic [15:0] fcmd, fout, rpm, e1, e2, rdata, d1, d2;
	logic [3:0]  addr;
	bit          ok;
	int          errors, checks_done, i;
	// flags {run,dir,jog,fcomm,fana,ccomm,lock}, index, expected word
	dsw_row_s rows [13] = '{'{9'h000, 4'h1, 16'h0000},
		'{9'h0b8, 4'h1, 16'h110d}, '{9'h145, 4'h1, 16'h1a12},
		'{9'h1e2, 4'h1, 16'h141b}, '{9'h000, 4'h0, 16'ha53c},
		'{9'h000, 4'h3, 16'h1770}, '{9'h000, 4'h4, 16'h0bb8},
		'{9'h000, 4'hc, 16'h0708}, '{9'h000, 4'hd, 16'hffff},
		'{9'h000, 4'he, 16'h8001}, '{9'h000, 4'h2, 16'h0000},
		'{9'h000, 4'h5, 16'h0000}, '{9'h000, 4'hf, 16'h0000}};
	//////////////////////////////////////////////////////////////////////
	dsw_bank dut_u (.i_clk(clk), .i_rst(rst), .i_fault_code(fault),
		.i_warn_code(warn), .i_run_state(run), .i_jog(jog),
		.i_dir_state(dir), .i_freq_from_comm(fc),
		.i_freq_from_analog(fa), .i_cmd_from_comm(cc),
		.i_param_locked(lk), .i_freq_cmd(fcmd), .i_freq_out(fout),
		.i_motor_rpm(rpm), .i_enc1_count(e1), .i_enc2_count(e2),
		.i_rd(rd), .i_wr(wr), .i_addr(addr), .o_rdata(rdata),
		.o_rvalid(rvalid));
	dsw_poller host_u (.i_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid),
		.o_rd(rd), .o_wr(wr), .o_addr(addr));
	//////////////////////////////////////////////////////////////////////
	// compare and count
	task automatic check(input string what, input logic [15:0] s,
		input logic [15:0] x);
		checks_done++;
		if (s !== x) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, x, s);
		end
	endtask
	// verdict and end of run
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// a missing answer strobe ends the run
	task automatic must(input bit good);
		if (!good) begin
			errors++;
			wrap_up();
		end
	endtask
	// 10 MHz clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// hang guard
	initial begin
		repeat (5000) @(posedge clk);
		errors++;
		wrap_up();
	end
	// main sequence, inputs change at falling edges
	initial begin
		{errors, checks_done} = '0;
		rst = 1'b1;
		{run, dir, jog, fc, fa, cc, lk} = 9'h000;
		{warn, fault} = 16'ha53c;
		{fcmd, fout, rpm} = {16'h1770, 16'h0bb8, 16'h0708};
		{e1, e2} = {16'hffff, 16'h8001};
		repeat (5) @(negedge clk);
		check("rvalid in reset", {15'h0000, rvalid}, 16'h0000);
		check("rdata in reset", rdata, 16'h0000);
		rst = 1'b0;
		$display("test reset done");
		for (i = 0; i < 13; i++) begin
			{run, dir, jog, fc, fa, cc, lk} = rows[i].fl;
			@(negedge clk);
			host_u.poll(rows[i].a, 4'h0, 1'b0, d1, d2, ok);
			must(ok);
			check("table word", d1, rows[i].e);
		end
		$display("test table done");
		host_u.poll(4'hd, 4'h3, 1'b1, d1, d2, ok);
		must(ok);
		check("first of pair", d1, 16'hffff);
		check("second of pair", d2, 16'h1770);
		@(negedge clk);
		check("strobe one cycle", {15'h0000, rvalid}, 16'h0000);
		$display("test back to back done");
		host_u.write_try(4'h3, seen);
		check("write answered", {15'h0000, seen}, 16'h0000);
		host_u.poll(4'h3, 4'h0, 1'b0, d1, d2, ok);
		must(ok);
		check("word after write", d1, 16'h1770);
		$display("test write ignored done");
		rst = 1'b1;
		@(negedge clk);
		check("rdata mid reset", rdata, 16'h0000);
		rst = 1'b0;
		host_u.poll(4'h0, 4'h0, 1'b0, d1, d2, ok);
		must(ok);
		check("codes after reset", d1, 16'ha53c);
		$display("test second reset done");
		wrap_up();
	end
endmodule

// File: hdl/dsw_bank.sv
// read-only bank of drive status words
`timescale 1ns/1ps
`include "dsw_cfg.svh"
// Functional notes
// - run state in bits one and zero
// - rotation state in bits four and three
// - bit 8 set for comm frequency source
// - bit 9 set for analog frequency source
// - bit 10 set for comm command source
// - bit 11 set while parameters locked
// - bit 12 high unless stopped
// - frequency command in hundredths of hertz
// - output frequency in hundredths of hertz
// - encoder one count, full 16 bits
// - second encoder position count, 16 bits
// - motor speed in rpm reported
module dsw_bank
	import dsw_pkg::*;
(
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	// drive state from the core
	input  wire logic [7:0]  i_fault_code,
	input  wire logic [7:0]  i_warn_code,
	input  wire logic [1:0]  i_run_state,
	input  wire logic        i_jog,
	input  wire logic [1:0]  i_dir_state,
	input  wire logic        i_freq_from_comm,
	input  wire logic        i_freq_from_analog,
	input  wire logic        i_cmd_from_comm,
	input  wire logic        i_param_locked,
	input  wire logic [15:0] i_freq_cmd,
	input  wire logic [15:0] i_freq_out,
	input  wire logic [15:0] i_motor_rpm,
	input  wire logic [15:0] i_enc1_count,
	input  wire logic [15:0] i_enc2_count,
	// status word read port
	input  wire logic        i_rd,
	input  wire logic        i_wr,
	input  wire logic [3:0]  i_addr,
	output logic [15:0]      o_rdata,
	output logic             o_rvalid
);
	////////////////////////////////////////////////////////////////////
	logic [15:0] flags_word;
	logic [15:0] fault_reg;
	logic [15:0] flags_reg;
	logic [15:0] fcmd_reg;
	logic [15:0] fout_reg;
	logic [15:0] speed_reg;
	logic [15:0] enc1_reg;
	logic [15:0] enc2_reg;
	logic [15:0] rdata_next;
	dsw_rd_e     rd_state_reg;

	dsw_flags u_flags (
		.i_run_state        (i_run_state),
		.i_jog              (i_jog),
		.i_dir_state        (i_dir_state),
		.i_freq_from_comm   (i_freq_from_comm),
		.i_freq_from_analog (i_freq_from_analog),
		.i_cmd_from_comm    (i_cmd_from_comm),
		.i_param_locked     (i_param_locked),
		.o_word             (flags_word)
	);

	////////////////////////////////////////////////////////////////////
	// snapshot of drive state each clock, cleared by reset
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			fault_reg <= `DSW_RESET_WORD;
			flags_reg <= `DSW_RESET_WORD;
			fcmd_reg  <= `DSW_RESET_WORD;
			fout_reg  <= `DSW_RESET_WORD;
			speed_reg <= `DSW_RESET_WORD;
			enc1_reg  <= `DSW_RESET_WORD;
			enc2_reg  <= `DSW_RESET_WORD;
		end else begin
			fault_reg <= {i_warn_code, i_fault_code};
			flags_reg <= flags_word;
			// frequency command, 6000 is 60.00 Hz
			fcmd_reg  <= i_freq_cmd;
			fout_reg  <= i_freq_out;
			speed_reg <= i_motor_rpm;
			enc1_reg  <= i_enc1_count;
			enc2_reg  <= i_enc2_count;
		end
	end

	////////////////////////////////////////////////////////////////////
	// read decode, unmapped words read zero
	always_comb begin
		if (i_addr == `DSW_IDX_FAULT) begin
			rdata_next = fault_reg;
		end else if (i_addr == `DSW_IDX_FLAGS) begin
			rdata_next = flags_reg;
		end else if (i_addr == `DSW_IDX_FCMD) begin
			rdata_next = fcmd_reg;
		end else if (i_addr == `DSW_IDX_FOUT) begin
			rdata_next = fout_reg;
		end else if (i_addr == `DSW_IDX_SPEED) begin
			rdata_next = speed_reg;
		end else if (i_addr == `DSW_IDX_ENC1) begin
			rdata_next = enc1_reg;
		end else if (i_addr == `DSW_IDX_ENC2) begin
			rdata_next = enc2_reg;
		end else begin
			rdata_next = `DSW_RESET_WORD;
		end
	end

	// read answer one cycle after the request; writes have no path in
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rd_state_reg <= DSW_RD_IDLE;
			o_rdata      <= `DSW_RESET_WORD;
			o_rvalid     <= 1'b0;
		end else begin
			case (rd_state_reg)
				DSW_RD_IDLE: begin
					o_rvalid <= i_rd;
					if (i_rd) begin
						o_rdata      <= rdata_next;
						rd_state_reg <= DSW_RD_ANS;
					end
				end
				DSW_RD_ANS: begin
					o_rvalid <= i_rd;
					if (i_rd) begin
						o_rdata <= rdata_next;
					end else begin
						rd_state_reg <= DSW_RD_IDLE;
					end
				end
				default: begin
					rd_state_reg <= DSW_RD_IDLE;
					o_rvalid     <= 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// running bit agrees with run field
	a_running_bit: assert property (@(posedge i_clk) disable iff (i_rst)
		flags_reg[`DSW_RUNNING_BIT] == (flags_reg[1:0] != 2'h0))
		else $error("running bit disagrees with run state");

	// run field follows input next cycle
	a_run_field: assert property (@(posedge i_clk) disable iff (i_rst)
		##1 flags_reg[1:0] == $past(i_run_state))
		else $error("run field wrong");

	a_dir_field: assert property (@(posedge i_clk) disable iff (i_rst)
		##1 flags_reg[4:3] == $past(i_dir_state))
		else $error("direction field wrong");

	a_fcomm_bit: assert property (@(posedge i_clk) disable iff (i_rst)
		##1 flags_reg[8] == $past(i_freq_from_comm))
		else $error("comm frequency bit wrong");

	a_fana_bit: assert property (@(posedge i_clk) disable iff (i_rst)
		##1 flags_reg[9] == $past(i_freq_from_analog))
		else $error("analog frequency bit wrong");

	a_ccomm_bit: assert property (@(posedge i_clk) disable iff (i_rst)
		##1 flags_reg[10] == $past(i_cmd_from_comm))
		else $error("command source bit wrong");

	a_lock_bit: assert property (@(posedge i_clk) disable iff (i_rst)
		##1 flags_reg[11] == $past(i_param_locked))
		else $error("lock bit wrong");

	a_resv_zero: assert property (@(posedge i_clk) disable iff (i_rst)
		flags_reg[15:13] == 3'h0 && flags_reg[7:5] == 3'h0)
		else $error("reserved flag bits not zero");

	// frequency read, two steps
	sequence s_fcmd_rd;
		i_rd && !i_wr && i_addr == 4'h3;
	endsequence
	a_fcmd_read: assert property (@(posedge i_clk) disable iff (i_rst)
		s_fcmd_rd |=> o_rvalid && o_rdata == $past(fcmd_reg))
		else $error("frequency command read wrong");

	a_fout_read: assert property (@(posedge i_clk) disable iff (i_rst)
		i_rd && i_addr == 4'h4 |=> o_rdata == $past(fout_reg))
		else $error("output frequency read wrong");

	a_enc1_read: assert property (@(posedge i_clk) disable iff (i_rst)
		i_rd && i_addr == 4'hd |=> o_rdata == $past(enc1_reg))
		else $error("encoder one read wrong");

	a_enc2_read: assert property (@(posedge i_clk) disable iff (i_rst)
		i_rd && i_addr == 4'he |=> o_rdata == $past(enc2_reg))
		else $error("encoder two read wrong");

	a_speed_read: assert property (@(posedge i_clk) disable iff (i_rst)
		i_rd && i_addr == 4'hc |=> o_rdata == $past(speed_reg))
		else $error("speed read wrong");

	a_unmapped_zero: assert property (@(posedge i_clk) disable iff (i_rst)
		i_rd && i_addr == 4'h2 |=> o_rdata == 16'h0000)
		else $error("unmapped word not zero");
endmodule

// File: hdl/dsw_cfg.svh
// constants for the drive status word bank
`ifndef DSW_CFG_SVH
`define DSW_CFG_SVH
// word indices of the status bank
`define DSW_IDX_FAULT     4'h0
`define DSW_IDX_FLAGS     4'h1
`define DSW_IDX_FCMD      4'h3
`define DSW_IDX_FOUT      4'h4
`define DSW_IDX_SPEED     4'hc
`define DSW_IDX_ENC1      4'hd
`define DSW_IDX_ENC2      4'he
// field positions inside the state flags word
`define DSW_RUN_LSB       0
`define DSW_JOG_BIT       2
`define DSW_DIR_LSB       3
`define DSW_FCOMM_BIT     8
`define DSW_FANA_BIT      9
`define DSW_CCOMM_BIT     10
`define DSW_LOCK_BIT      11
`define DSW_RUNNING_BIT   12
`define DSW_RESET_WORD    16'h0000
`endif

// File: hdl/dsw_flags.sv
// packs the drive state flags into one status word
`timescale 1ns/1ps
`include "dsw_cfg.svh"
module dsw_flags
	import dsw_pkg::*;
(
	// drive state
	input  wire logic [1:0] i_run_state,
	input  wire logic       i_jog,
	input  wire logic [1:0] i_dir_state,
	input  wire logic       i_freq_from_comm,
	input  wire logic       i_freq_from_analog,
	input  wire logic       i_cmd_from_comm,
	input  wire logic       i_param_locked,
	// packed word
	output logic [15:0]     o_word
);
	// true for every run state other than stopped
	function automatic logic dsw_is_running(input logic [1:0] st);
		return st != DSW_RUN_STOPPED;
	endfunction

	// reserved positions stay zero
	always_comb begin
		o_word = `DSW_RESET_WORD;
		o_word[`DSW_RUN_LSB+:2] = i_run_state;
		o_word[`DSW_JOG_BIT] = i_jog;
		o_word[`DSW_DIR_LSB+:2] = i_dir_state;
		o_word[`DSW_FCOMM_BIT] = i_freq_from_comm;
		o_word[`DSW_FANA_BIT] = i_freq_from_analog;
		o_word[`DSW_CCOMM_BIT] = i_cmd_from_comm;
		o_word[`DSW_LOCK_BIT] = i_param_locked;
		o_word[`DSW_RUNNING_BIT] = dsw_is_running(i_run_state);
	end
endmodule

// File: hdl/dsw_pkg.sv
// types for the drive status word bank
package dsw_pkg;
	typedef logic [15:0] dsw_word_t;
	// run state codes of the two-bit run field
	typedef enum logic [1:0] {
		DSW_RUN_STOPPED = 2'h0,
		DSW_RUN_DECEL   = 2'h1,
		DSW_RUN_STANDBY = 2'h2,
		DSW_RUN_RUNNING = 2'h3
	} dsw_run_e;
	// rotation codes of the two-bit direction field
	typedef enum logic [1:0] {
		DSW_DIR_FWD     = 2'h0,
		DSW_DIR_REV2FWD = 2'h1,
		DSW_DIR_FWD2REV = 2'h2,
		DSW_DIR_REV     = 2'h3
	} dsw_dir_e;
	// one-hot phases of the read port
	typedef enum logic [1:0] {
		DSW_RD_IDLE = 2'b01,
		DSW_RD_ANS  = 2'b10
	} dsw_rd_e;
endpackage
